/* File: testbench/ubdfc_checker.sv */
// Purpose: Port checks for the divisor and flow control block.
// Assumes: One clock; reset_n synchronous, active low.
// Notes: Bound to ubdfc_top below; judges design outputs only.
`timescale 1ns/10ps
`default_nettype none
`include "ubdfc_defines.vh"
module ubdfc_checker
(
  input wire clock,
  input wire reset_n,
  input wire [3:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrite,
  input wire regRead,
  input wire [7:0] regRdData_r,
  input wire rxCharValid,
  input wire [7:0] rxChar,
  input wire nineBitMode,
  input wire txIdle,
  input wire rxStore_r,
  input wire [7:0] rxStoreData_r,
  input wire insertValid_r,
  input wire level5Irq_r,
  input wire enhancedMode_r,
  input wire sampleTick_r,
  input wire baudTick_r,
  input wire [7:0] indexOffset_r
);
  logic [4:0] sampleCnt_r;
  default clocking dc @(posedge clock); endclocking
  default disable iff (!reset_n);
  // Sample ticks since the last baud tick; a missing baud tick shows as an overrun.
  always @(posedge clock)
    if (!reset_n || baudTick_r)
      sampleCnt_r <= 5'h0;
    else if (sampleTick_r)
      sampleCnt_r <= sampleCnt_r + 5'h1;
  chk_baud_sixteen: assert property (sampleCnt_r <= 5'h10)
    else $error("baud tick missing after sixteen sample ticks");
  chk_read_window: assert property (regRdData_r != 8'h00 |-> $past(regRead))
    else $error("read data outside its cycle");
  chk_index_mirror: assert property (regWrite && regAddr == `UBDFC_ADDR_SCRATCH
    |-> ##2 indexOffset_r == $past(regWrData, 2))
    else $error("index offset does not follow scratch");
  chk_nine_bit_quiet: assert property ($past(nineBitMode) |-> !insertValid_r)
    else $error("flow character inserted in nine bit mode");
  chk_level5_enh: assert property (level5Irq_r |-> enhancedMode_r || $past(enhancedMode_r))
    else $error("level five interrupt outside enhanced mode");
  chk_store_cause: assert property (rxStore_r |-> $past(rxCharValid))
    else $error("store without a received character");
  chk_store_data: assert property (rxStore_r |-> rxStoreData_r == $past(rxChar))
    else $error("stored character differs from received one");
  chk_insert_idle: assert property (insertValid_r |-> $past(txIdle) && !$past(insertValid_r))
    else $error("insert while transmitter busy");
  chk_insert_single: assert property (insertValid_r |=> !insertValid_r)
    else $error("insert pulse longer than one cycle");
  chk_source_code: assert property (regRead && regAddr == `UBDFC_ADDR_IRQ_SRC && level5Irq_r
    |=> regRdData_r == {2'b00, `UBDFC_SRC_LEVEL5})
    else $error("level five source code wrong");
endmodule
bind ubdfc_top ubdfc_checker chk (.clock, .reset_n, .regAddr, .regWrData, .regWrite, .regRead,
  .regRdData_r, .rxCharValid, .rxChar, .nineBitMode, .txIdle, .rxStore_r, .rxStoreData_r,
  .insertValid_r, .level5Irq_r, .enhancedMode_r, .sampleTick_r, .baudTick_r, .indexOffset_r);
`default_nettype wire

/* File: testbench/ubdfc_remote_model.sv */
// Purpose: Remote station and local line transmitter stub.
// Assumes: Characters arrive as one-cycle strobes.
// Notes: The data bus shows the inverse of the last character between frames.
`timescale 1ns/10ps
`default_nettype none
module ubdfc_remote_model
(
  input wire logic clock,
  input wire logic insertValid_r,
  output logic rxCharValid,
  output logic [7:0] rxChar,
  output logic ctsN,
  output logic dsrN,
  output logic txIdle
);
  logic [2:0] busy_r = 3'h0;
  initial
  begin
    rxCharValid = 1'b0;
    rxChar = 8'h00;
    ctsN = 1'b0;
    dsrN = 1'b0;
  end
  // The transmitter is busy four cycles per inserted flow character.
  always @(posedge clock)
    busy_r <= insertValid_r ? 3'h4 : (busy_r != 3'h0 ? busy_r - 3'h1 : 3'h0);
  assign txIdle = (busy_r == 3'h0);
  task automatic sendChar(input logic [7:0] c);
    @(posedge clock);
    rxCharValid <= 1'b1;
    rxChar <= c;
    @(posedge clock);
    rxCharValid <= 1'b0;
    rxChar <= ~c;
  endtask
  task automatic setModem(input logic cts, input logic dsr);
    @(posedge clock);
    ctsN <= cts;
    dsrN <= dsr;
  endtask
endmodule
`default_nettype wire

/* File: testbench/ubdfc_test.sv */
// Purpose: Self-checking bench for the divisor and flow control block.
// Assumes: The bench acts as host, receive FIFO and line.
// Notes: Flow characters are counted by a monitor, so late inserts are still seen.
`timescale 1ns/10ps
`default_nettype none
`include "ubdfc_defines.vh"
module ubdfc_test;
  logic clock, reset_n, regWrite, regRead, nineBitMode;
  logic [3:0] regAddr;
  logic [7:0] regWrData, rxFillLevel, rdv, insLast;
  wire logic [7:0] regRdData_r, rxChar, rxStoreData_r, insertChar_r, indexOffset_r;
  wire logic rxCharValid, txIdle, ctsN, dsrN, rxStore_r, insertValid_r, txHold_r, rtsN_r, dtrN_r;
  wire logic level5Irq_r, enhancedMode_r;
  int fails = 0;
  int samplesChecked = 0;
  int insCnt = 0;
  ubdfc_top uut (.clock(clock), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData_r(regRdData_r), .rxCharValid(rxCharValid),
    .rxChar(rxChar), .nineBitMode(nineBitMode), .rxFillLevel(rxFillLevel), .upperThresh(8'h64),
    .lowerThresh(8'h32), .txIdle(txIdle), .ctsN(ctsN), .dsrN(dsrN), .rxStore_r(rxStore_r),
    .rxStoreData_r(rxStoreData_r), .insertValid_r(insertValid_r), .insertChar_r(insertChar_r),
    .txHold_r(txHold_r), .rtsN_r(rtsN_r), .dtrN_r(dtrN_r), .level5Irq_r(level5Irq_r),
    .enhancedMode_r(enhancedMode_r), .sampleTick_r(), .baudTick_r(), .indexOffset_r(indexOffset_r));
  ubdfc_remote_model remote (.clock(clock), .insertValid_r(insertValid_r), .rxCharValid(rxCharValid),
    .rxChar(rxChar), .ctsN(ctsN), .dsrN(dsrN), .txIdle(txIdle));
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Count inserted flow characters as the transmitter would take them.
  always @(posedge clock)
    if (insertValid_r === 1'b1)
    begin
      insCnt <= insCnt + 1;
      insLast <= insertChar_r;
    end
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    samplesChecked++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic testDone;
    $display("checks %0d errors %0d", samplesChecked, fails);
    if (fails == 0 && samplesChecked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask
  task automatic rdChk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1;
    chk("register", exp, regRdData_r);
  endtask
  // Feature writes only land while the line format holds the access key.
  task automatic setFeat(input logic [7:0] v);
    wr(`UBDFC_ADDR_LINE_FMT, `UBDFC_ENH_KEY);
    wr(`UBDFC_ADDR_FEATURE, v);
    wr(`UBDFC_ADDR_LINE_FMT, 8'h03);
  endtask
  task automatic rxChk(input logic [7:0] c, input logic st, input logic hold);
    remote.sendChar(c);
    #1;
    chk("store", {7'h0, st}, {7'h0, rxStore_r});
    if (st)
      chk("stored", c, rxStoreData_r);
    cyc(1);
    chk("hold", {7'h0, hold}, {7'h0, txHold_r});
  endtask
  task automatic setFill(input logic [7:0] v);
    @(posedge clock);
    rxFillLevel <= v;
    cyc(3);
  endtask
  task automatic resetScen;
    rdChk(`UBDFC_ADDR_DIV_LO, 8'h01);
    rdChk(`UBDFC_ADDR_DIV_HI, 8'h00);
    rdChk(4'hF, 8'h00);
    chk("rts", 8'h01, {7'h0, rtsN_r});
    chk("enh", 8'h00, {7'h0, enhancedMode_r});
    wr(`UBDFC_ADDR_LINE_FMT, `UBDFC_ENH_KEY);
    rdChk(`UBDFC_ADDR_FEATURE, 8'h00);
    wr(`UBDFC_ADDR_LINE_FMT, 8'h03);
  endtask
  task automatic baudScen;
    int n;
    wr(`UBDFC_ADDR_DIV_LO, 8'h03);
    for (int k = 0; k < 3; k++)
    begin
      n = 0;
      do
      begin
        cyc(1);
        n++;
      end
      while (uut.baudTick_r !== 1'b1 && n < 200);
      if (n >= 200)
      begin
        fails++;
        testDone;
      end
    end
    chk("baud period", 8'h30, n[7:0]);
    wr(`UBDFC_ADDR_DIV_LO, 8'h01);
  endtask
  task automatic regScen;
    wr(`UBDFC_ADDR_SCRATCH, 8'hA5);
    rdChk(`UBDFC_ADDR_SCRATCH, 8'hA5);
    chk("index", 8'hA5, indexOffset_r);
    rdChk(`UBDFC_ADDR_DIV_LO, 8'h01);
    wr(`UBDFC_ADDR_FEATURE, 8'h10);
    cyc(2);
    chk("enh", 8'h00, {7'h0, enhancedMode_r});
    setFeat(8'h10);
    cyc(1);
    chk("enh", 8'h01, {7'h0, enhancedMode_r});
    rdChk(`UBDFC_ADDR_FEATURE, 8'h00);
  endtask
  task automatic inbandScen;
    wr(`UBDFC_ADDR_LINE_FMT, `UBDFC_ENH_KEY);
    for (int i = 0; i < 4; i++)
      wr(`UBDFC_ADDR_RESUME1 + i[3:0], 8'h11 + i[7:0]);
    wr(`UBDFC_ADDR_FEATURE, 8'h1A);
    wr(`UBDFC_ADDR_LINE_FMT, 8'h03);
    wr(`UBDFC_ADDR_IRQ_EN, 8'h20);
    wr(`UBDFC_ADDR_MODEM_CTL, 8'h02);
    rxChk(8'h13, 1'b0, 1'b1);
    chk("irq", 8'h01, {7'h0, level5Irq_r});
    rdChk(`UBDFC_ADDR_EXTRA_STAT, 8'h01);
    rdChk(`UBDFC_ADDR_IRQ_SRC, 8'h10);
    cyc(2);
    chk("irq", 8'h00, {7'h0, level5Irq_r});
    rxChk(8'h41, 1'b1, 1'b1);
    rxChk(8'h11, 1'b0, 1'b0);
    rdChk(`UBDFC_ADDR_EXTRA_STAT, 8'h00);
    rxChk(8'h13, 1'b0, 1'b1);
    wr(`UBDFC_ADDR_MODEM_CTL, 8'h22);
    rxChk(8'h42, 1'b1, 1'b0);
    wr(`UBDFC_ADDR_MODEM_CTL, 8'h02);
    // receive field decode, never 11 with transmit off
    for (int f = 1; f < 4; f++)
    begin
      setFeat(8'h18 | f[7:0]);
      rxChk(8'h14, f == 2, f != 2);
      rxChk(8'h12, f == 2, 1'b0);
    end
    rdChk(`UBDFC_ADDR_IRQ_SRC, 8'h10);
    setFeat(8'h0A);
    rxChk(8'h13, 1'b1, 1'b0);
  endtask
  task automatic specialScen;
    setFeat(8'h30);
    wr(`UBDFC_ADDR_IRQ_EN, 8'h20);
    rxChk(8'h14, 1'b1, 1'b0);
    chk("irq", 8'h01, {7'h0, level5Irq_r});
    rdChk(`UBDFC_ADDR_EXTRA_STAT, 8'h10);
    rdChk(`UBDFC_ADDR_EXTRA_STAT, 8'h00);
    rdChk(`UBDFC_ADDR_IRQ_SRC, 8'h10);
    rdChk(`UBDFC_ADDR_IRQ_SRC, 8'h01);
  endtask
  task automatic oobScen;
    setFeat(8'h00);
    wr(`UBDFC_ADDR_MODEM_CTL, 8'h23);
    setFill(8'h64);
    chk("rts", 8'h01, {7'h0, rtsN_r});
    setFill(8'h31);
    chk("rts", 8'h00, {7'h0, rtsN_r});
    remote.setModem(1'b1, 1'b0);
    cyc(3);
    chk("hold", 8'h01, {7'h0, txHold_r});
    remote.setModem(1'b0, 1'b0);
    cyc(3);
    chk("hold", 8'h00, {7'h0, txHold_r});
    wr(`UBDFC_ADDR_MODEM_CTL, 8'h21);
    cyc(2);
    chk("rts", 8'h01, {7'h0, rtsN_r});
    wr(`UBDFC_ADDR_MODEM_CTL, 8'h03);
    wr(`UBDFC_ADDR_EXTRA_CTL, 8'h0C);
    setFill(8'h64);
    chk("dtr", 8'h01, {7'h0, dtrN_r});
    remote.setModem(1'b0, 1'b1);
    cyc(3);
    chk("hold", 8'h01, {7'h0, txHold_r});
    remote.setModem(1'b0, 1'b0);
    wr(`UBDFC_ADDR_EXTRA_CTL, 8'h00);
    setFeat(8'h50);
    remote.setModem(1'b1, 1'b0);
    cyc(3);
    chk("rts", 8'h01, {7'h0, rtsN_r});
    chk("hold", 8'h00, {7'h0, txHold_r});
    remote.setModem(1'b0, 1'b0);
    setFill(8'h00);
  endtask
  task automatic txScen;
    // transmit field, never the reserved 11
    setFeat(8'h18);
    setFill(8'h65);
    cyc(20);
    chk("inserts", 8'h01, insCnt[7:0]);
    chk("pause char", 8'h13, insLast);
    rdChk(`UBDFC_ADDR_EXTRA_STAT, 8'h02);
    setFill(8'h31);
    cyc(20);
    chk("resume char", 8'h11, insLast);
    setFill(8'h65);
    setFeat(8'h10);
    cyc(20);
    chk("inserts", 8'h04, insCnt[7:0]);
    chk("resume char", 8'h11, insLast);
    @(posedge clock);
    nineBitMode <= 1'b1;
    setFeat(8'h18);
    cyc(20);
    chk("inserts", 8'h04, insCnt[7:0]);
    // Pair two is selected while nine-bit framing still blocks inserts.
    setFeat(8'h14);
    @(posedge clock);
    nineBitMode <= 1'b0;
    cyc(20);
    chk("inserts", 8'h05, insCnt[7:0]);
    chk("pause char", 8'h14, insLast);
    setFill(8'h31);
    cyc(20);
    chk("resume char", 8'h12, insLast);
  endtask
  initial
  begin
    reset_n = 1'b0;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 4'h0;
    regWrData = 8'h00;
    nineBitMode = 1'b0;
    rxFillLevel = 8'h00;
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    resetScen();
    baudScen();
    regScen();
    inbandScen();
    specialScen();
    oobScen();
    txScen();
    testDone();
  end
endmodule
`default_nettype wire

/* File: verilog/ubdfc_defines.vh */
// Purpose: Constants for the baud divisor and automatic flow control block.
// Assumes: Register port with an 8-bit data path and a 4-bit word address.
// Notes: Every offset, one-bit field position and software register reset value of the block lives here.
//
// Functional notes
// - Divisor is low plus 256 times high; baud is clock over 16 times divisor.
// - Scratch byte stores anything, affects nothing, and doubles as index offset.
// - Writing 0xBF to line format sets bit 7 only and opens enhanced access.
// - In-band flow control both ways is off during 9-bit framing, except the resume sent if the remote was already paused.
// - Receive field: 00 off, 01 pair two, 10 pair one, 11 either pair while transmit field is 01 or 10.
// - Transmit field: 00 off, 01 pair two, 10 pair one, 11 reserved.
// - Enhanced bit clear masks enhanced enables and ignores other feature bits.
// - Special detect of pause two stores it, sets status bit 4, level-5 interrupt.
// - Match characters are accepted regardless of parity or framing errors.
// - Valid pause stops transmit after current character, sets pause flags, interrupt.
// - While paused, a resume match restarts transmit and clears pause flags.
// - Resume and pause characters are not stored, except special pause two.
// - Resume-on-any: any character but a pause match resumes transmit; all but flow matches are still stored.
// - Transmitter idle: send pause above upper, resume below lower threshold.
// - Turning transmit in-band off while remote paused sends a resume.
// - Non-enhanced modem bit 5 enables both; enhanced uses feature bits 6, 7.
// - Automatic CTS holds new transmission while CTS# is high.
// - Automatic RTS deasserts at upper threshold, reasserts below lower, ANDed.
// - DTR/DSR handshake mirrors RTS/CTS, enabled by extra control bits 3:2.
// - Level-5 code is 010000, cleared by a source read while reported.
// - Software RTS bit 0 forces RTS# high; 1 drives it low.
`ifndef UBDFC_DEFINES_VH
`define UBDFC_DEFINES_VH

// Register word addresses.
`define UBDFC_ADDR_DIV_LO 4'h0
`define UBDFC_ADDR_DIV_HI 4'h1
`define UBDFC_ADDR_LINE_FMT 4'h2
`define UBDFC_ADDR_MODEM_CTL 4'h3
`define UBDFC_ADDR_SCRATCH 4'h4
`define UBDFC_ADDR_FEATURE 4'h5
`define UBDFC_ADDR_RESUME1 4'h6
`define UBDFC_ADDR_RESUME2 4'h7
`define UBDFC_ADDR_PAUSE1 4'h8
`define UBDFC_ADDR_PAUSE2 4'h9
`define UBDFC_ADDR_EXTRA_CTL 4'hA
`define UBDFC_ADDR_IRQ_EN 4'hB
`define UBDFC_ADDR_IRQ_SRC 4'hC
`define UBDFC_ADDR_EXTRA_STAT 4'hD

// Values and reset values.
`define UBDFC_ENH_KEY 8'hBF
`define UBDFC_DIV_LO_RST 8'h01
`define UBDFC_ZERO8 8'h00
`define UBDFC_SRC_LEVEL5 6'h10
`define UBDFC_SRC_NONE 6'h01
`define UBDFC_OVERSAMPLE 5'h10

// Field positions.
`define UBDFC_FEAT_ENH 4
`define UBDFC_FEAT_SPECIAL 5
`define UBDFC_FEAT_AUTO_RTS 6
`define UBDFC_FEAT_AUTO_CTS 7
`define UBDFC_MCR_DTR 0
`define UBDFC_MCR_RTS 1
`define UBDFC_MCR_ANY 5
`define UBDFC_ACR_AUTO_DSR 2
`define UBDFC_ACR_AUTO_DTR 3
`define UBDFC_IER_LEVEL5 5
`define UBDFC_ASR_PAUSED 0
`define UBDFC_ASR_REMOTE 1
`define UBDFC_ASR_SPECIAL 4
`define UBDFC_LCR_ACCESS 7

`endif

/* File: verilog/ubdfc_top.v */
// Purpose: Baud divisor, scratch byte, enhanced access and automatic flow control.
// Assumes: Single 100 MHz clock; all inputs synchronous; synchronous active-low reset.
// Notes: The transmitter finishes any character in progress itself when txHold rises.
//
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "ubdfc_defines.vh"

module ubdfc_top
(
  input wire clock,
  input wire reset_n,
  input wire [3:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrite,
  input wire regRead,
  output reg [7:0] regRdData_r,
  input wire rxCharValid,
  input wire [7:0] rxChar,
  input wire nineBitMode,
  input wire [7:0] rxFillLevel,
  input wire [7:0] upperThresh,
  input wire [7:0] lowerThresh,
  input wire txIdle,
  input wire ctsN,
  input wire dsrN,
  output reg rxStore_r,
  output reg [7:0] rxStoreData_r,
  output reg insertValid_r,
  output reg [7:0] insertChar_r,
  output reg txHold_r,
  output reg rtsN_r,
  output reg dtrN_r,
  output reg level5Irq_r,
  output reg enhancedMode_r,
  output reg sampleTick_r,
  output reg baudTick_r,
  output reg [7:0] indexOffset_r
);

  // Software-visible registers.
  reg [7:0] divLo_r;
  reg [7:0] divHi_r;
  reg [7:0] lineFmt_r;
  reg [7:0] modemCtl_r;
  reg [7:0] scratch_r;
  reg [7:0] feature_r;
  reg [7:0] resume1_r;
  reg [7:0] resume2_r;
  reg [7:0] pause1_r;
  reg [7:0] pause2_r;
  reg [7:0] extraCtl_r;
  reg [7:0] irqEn_r;
  reg accessOpen_r;

  // Flow-control state and baud divider counters.
  reg paused_r;
  reg remotePaused_r;
  reg special_r;
  reg level5Pend_r;
  reg rtsHold_r;
  reg sentPairOne_r;
  reg [15:0] divCnt_r;
  reg [3:0] sampleCnt_r;

  wire wrEn;
  wire enh;
  wire inbandOk;
  wire [1:0] rxMode;
  wire [1:0] txMode;
  wire rxOn;
  wire txOn;
  wire [15:0] divisor;
  wire srcRead;
  wire statRead;

  assign enh = feature_r[`UBDFC_FEAT_ENH];
  assign inbandOk = enh & ~nineBitMode;
  assign rxMode = enh ? feature_r[1:0] : 2'b00;
  assign txMode = enh ? feature_r[3:2] : 2'b00;
  assign rxOn = inbandOk & (rxMode != 2'b00);
  assign txOn = inbandOk & (txMode == 2'b01 || txMode == 2'b10);
  assign divisor = {divHi_r, divLo_r};
  assign wrEn = regWrite;
  assign srcRead = regRead & (regAddr == `UBDFC_ADDR_IRQ_SRC);
  assign statRead = regRead & (regAddr == `UBDFC_ADDR_EXTRA_STAT);

  // Receive character matching; only the data byte is compared, never its error status.
  reg matchPause;
  reg matchResume;
  reg matchSpecial;
  always @*
  begin
    matchPause = 1'b0;
    matchResume = 1'b0;
    case (rxMode)
      2'b01:
      begin
        matchPause = (rxChar == pause2_r);
        matchResume = (rxChar == resume2_r);
      end
      2'b10:
      begin
        matchPause = (rxChar == pause1_r);
        matchResume = (rxChar == resume1_r);
      end
      2'b11:
      begin
        if (txMode == 2'b01 || txMode == 2'b10)
        begin
          matchPause = (rxChar == pause1_r) || (rxChar == pause2_r);
          matchResume = (rxChar == resume1_r) || (rxChar == resume2_r);
        end
      end
      default:
      begin
        matchPause = 1'b0;
        matchResume = 1'b0;
      end
    endcase
    matchPause = matchPause & rxOn;
    matchResume = matchResume & rxOn;
    matchSpecial = enh & feature_r[`UBDFC_FEAT_SPECIAL] & (rxChar == pause2_r);
  end

  wire gotPause;
  wire gotResume;
  wire anyResume;
  wire gotSpecial;
  assign gotPause = rxCharValid & matchPause;
  assign gotResume = rxCharValid & paused_r & matchResume;
  assign anyResume = rxCharValid & paused_r & rxOn & enh & modemCtl_r[`UBDFC_MCR_ANY];
  assign gotSpecial = rxCharValid & matchSpecial;

  // Register writes. The feature register is only reachable while the key is in line format.
  always @(posedge clock)
  begin
    if (!reset_n)
    begin
      divLo_r <= `UBDFC_DIV_LO_RST;
      divHi_r <= `UBDFC_ZERO8;
      lineFmt_r <= `UBDFC_ZERO8;
      modemCtl_r <= `UBDFC_ZERO8;
      scratch_r <= `UBDFC_ZERO8;
      feature_r <= `UBDFC_ZERO8;
      resume1_r <= `UBDFC_ZERO8;
      resume2_r <= `UBDFC_ZERO8;
      pause1_r <= `UBDFC_ZERO8;
      pause2_r <= `UBDFC_ZERO8;
      extraCtl_r <= `UBDFC_ZERO8;
      irqEn_r <= `UBDFC_ZERO8;
      accessOpen_r <= 1'b0;
    end
    else if (wrEn)
    begin
      case (regAddr)
        `UBDFC_ADDR_DIV_LO: divLo_r <= regWrData;
        `UBDFC_ADDR_DIV_HI: divHi_r <= regWrData;
        `UBDFC_ADDR_LINE_FMT:
        begin
          if (regWrData == `UBDFC_ENH_KEY)
          begin
            lineFmt_r[`UBDFC_LCR_ACCESS] <= 1'b1;
            accessOpen_r <= 1'b1;
          end
          else
          begin
            lineFmt_r <= regWrData;
            accessOpen_r <= 1'b0;
          end
        end
        `UBDFC_ADDR_MODEM_CTL:
        begin
          // bits 6-7 held outside enhanced mode
          modemCtl_r[5:0] <= regWrData[5:0];
          if (enh)
          begin
            modemCtl_r[7:6] <= regWrData[7:6];
          end
        end
        `UBDFC_ADDR_SCRATCH: scratch_r <= regWrData;
        `UBDFC_ADDR_FEATURE:
        begin
          if (accessOpen_r)
          begin
            feature_r <= regWrData;
          end
        end
        `UBDFC_ADDR_RESUME1: resume1_r <= regWrData;
        `UBDFC_ADDR_RESUME2: resume2_r <= regWrData;
        `UBDFC_ADDR_PAUSE1: pause1_r <= regWrData;
        `UBDFC_ADDR_PAUSE2: pause2_r <= regWrData;
        `UBDFC_ADDR_EXTRA_CTL: extraCtl_r <= regWrData;
        `UBDFC_ADDR_IRQ_EN:
        begin
          irqEn_r[3:0] <= regWrData[3:0];
          irqEn_r[7:4] <= enh ? regWrData[7:4] : 4'h0;
        end
        default: divLo_r <= divLo_r;
      endcase
    end
  end

  // Receive-side pause state, special flag and the level-5 pending bit; sets beat clears.
  always @(posedge clock)
  begin
    if (!reset_n)
    begin
      paused_r <= 1'b0;
      special_r <= 1'b0;
      level5Pend_r <= 1'b0;
    end
    else
    begin
      if (gotPause)
      begin
        paused_r <= 1'b1;
      end
      else if (gotResume || anyResume || !rxOn)
      begin
        paused_r <= 1'b0;
      end
      if (gotSpecial)
      begin
        special_r <= 1'b1;
      end
      else if (statRead)
      begin
        special_r <= 1'b0;
      end
      if (gotPause || gotSpecial)
      begin
        level5Pend_r <= 1'b1;
      end
      else if (srcRead && level5Pend_r)
      begin
        level5Pend_r <= 1'b0;
      end
    end
  end

  // Receive holding path: matched flow characters are swallowed, except a special pause two.
  always @(posedge clock)
  begin
    if (!reset_n)
    begin
      rxStore_r <= 1'b0;
      rxStoreData_r <= `UBDFC_ZERO8;
    end
    else
    begin
      rxStore_r <= rxCharValid & (~(matchPause | matchResume) | gotSpecial);
      if (rxCharValid)
      begin
        rxStoreData_r <= rxChar;
      end
    end
  end

  // In-band transmit: insert pause or resume only while the transmitter is idle.
  // Skipping the cycle after an insert gives the transmitter time to drop txIdle.
  always @(posedge clock)
  begin
    if (!reset_n)
    begin
      remotePaused_r <= 1'b0;
      sentPairOne_r <= 1'b0;
      insertValid_r <= 1'b0;
      insertChar_r <= `UBDFC_ZERO8;
    end
    else
    begin
      insertValid_r <= 1'b0;
      if (txIdle && !insertValid_r)
      begin
        if (txOn && !remotePaused_r && rxFillLevel > upperThresh)
        begin
          insertValid_r <= 1'b1;
          insertChar_r <= (txMode == 2'b10) ? pause1_r : pause2_r;
          sentPairOne_r <= (txMode == 2'b10);
          remotePaused_r <= 1'b1;
        end
        else if (txOn && remotePaused_r && rxFillLevel < lowerThresh)
        begin
          insertValid_r <= 1'b1;
          insertChar_r <= sentPairOne_r ? resume1_r : resume2_r;
          remotePaused_r <= 1'b0;
        end
        else if (!txOn && remotePaused_r)
        begin
          insertValid_r <= 1'b1;
          insertChar_r <= sentPairOne_r ? resume1_r : resume2_r;
          remotePaused_r <= 1'b0;
        end
      end
    end
  end

  // Out-of-band handshake enables; RTS and CTS selected by mode, DTR and DSR by extra control.
  wire autoRts;
  wire autoCts;
  wire autoDtr;
  wire autoDsr;
  assign autoRts = enh ? feature_r[`UBDFC_FEAT_AUTO_RTS] : modemCtl_r[`UBDFC_MCR_ANY];
  assign autoCts = enh ? feature_r[`UBDFC_FEAT_AUTO_CTS] : modemCtl_r[`UBDFC_MCR_ANY];
  assign autoDtr = extraCtl_r[`UBDFC_ACR_AUTO_DTR];
  assign autoDsr = extraCtl_r[`UBDFC_ACR_AUTO_DSR];

  // Receive-level hysteresis shared by RTS# and DTR#, and the modem outputs.
  always @(posedge clock)
  begin
    if (!reset_n)
    begin
      rtsHold_r <= 1'b0;
      rtsN_r <= 1'b1;
      dtrN_r <= 1'b1;
      txHold_r <= 1'b0;
    end
    else
    begin
      if (rxFillLevel >= upperThresh)
      begin
        rtsHold_r <= 1'b1;
      end
      else if (rxFillLevel < lowerThresh)
      begin
        rtsHold_r <= 1'b0;
      end
      rtsN_r <= ~(modemCtl_r[`UBDFC_MCR_RTS] & ~(autoRts & rtsHold_r));
      dtrN_r <= ~(modemCtl_r[`UBDFC_MCR_DTR] & ~(autoDtr & rtsHold_r));
      txHold_r <= paused_r | (autoCts & ctsN) | (autoDsr & dsrN);
    end
  end

  // Baud divider: a tick every divisor cycles, and a baud tick every 16 of those.
  // A zero divisor stops both ticks rather than dividing by 65536.
  always @(posedge clock)
  begin
    if (!reset_n)
    begin
      divCnt_r <= 16'h0000;
      sampleCnt_r <= 4'h0;
      sampleTick_r <= 1'b0;
      baudTick_r <= 1'b0;
    end
    else
    begin
      sampleTick_r <= 1'b0;
      baudTick_r <= 1'b0;
      if (divisor == 16'h0000)
      begin
        divCnt_r <= 16'h0000;
        sampleCnt_r <= 4'h0;
      end
      else if (divCnt_r >= divisor - 16'h0001)
      begin
        divCnt_r <= 16'h0000;
        sampleTick_r <= 1'b1;
        sampleCnt_r <= sampleCnt_r + 4'h1;
        if (sampleCnt_r == 4'hF)
        begin
          baudTick_r <= 1'b1;
        end
      end
      else
      begin
        divCnt_r <= divCnt_r + 16'h0001;
      end
    end
  end

  // Read port and remaining status outputs.
  always @(posedge clock)
  begin
    if (!reset_n)
    begin
      regRdData_r <= `UBDFC_ZERO8;
      level5Irq_r <= 1'b0;
      enhancedMode_r <= 1'b0;
      indexOffset_r <= `UBDFC_ZERO8;
    end
    else
    begin
      level5Irq_r <= level5Pend_r & irqEn_r[`UBDFC_IER_LEVEL5] & enh;
      enhancedMode_r <= enh;
      indexOffset_r <= scratch_r;
      if (regRead)
      begin
        case (regAddr)
          `UBDFC_ADDR_DIV_LO: regRdData_r <= divLo_r;
          `UBDFC_ADDR_DIV_HI: regRdData_r <= divHi_r;
          `UBDFC_ADDR_LINE_FMT: regRdData_r <= lineFmt_r;
          `UBDFC_ADDR_MODEM_CTL: regRdData_r <= modemCtl_r;
          `UBDFC_ADDR_SCRATCH: regRdData_r <= scratch_r;
          `UBDFC_ADDR_FEATURE: regRdData_r <= accessOpen_r ? feature_r : `UBDFC_ZERO8;
          `UBDFC_ADDR_RESUME1: regRdData_r <= resume1_r;
          `UBDFC_ADDR_RESUME2: regRdData_r <= resume2_r;
          `UBDFC_ADDR_PAUSE1: regRdData_r <= pause1_r;
          `UBDFC_ADDR_PAUSE2: regRdData_r <= pause2_r;
          `UBDFC_ADDR_EXTRA_CTL: regRdData_r <= extraCtl_r;
          `UBDFC_ADDR_IRQ_EN: regRdData_r <= irqEn_r;
          `UBDFC_ADDR_IRQ_SRC:
            regRdData_r <= {2'b00, level5Pend_r ? `UBDFC_SRC_LEVEL5 : `UBDFC_SRC_NONE};
          `UBDFC_ADDR_EXTRA_STAT:
            regRdData_r <= {3'b000, special_r, 2'b00, remotePaused_r, paused_r};
          default: regRdData_r <= `UBDFC_ZERO8;
        endcase
      end
      else
      begin
        regRdData_r <= `UBDFC_ZERO8;
      end
    end
  end

endmodule

`default_nettype wire
